// File: hdl/pts_stage.sv
// Programmable threshold stage: scaling, comparators, delays, status
`timescale 1ns/10ps
`include "pts_map.svh"

module pts_stage
	import pts_pkg::*;
#(
	parameter int unsigned TICK_CYC = `PTS_TICK_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [2:0][31:0] meas,
	input  wire logic        block_in,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wr_data,
	input  wire logic        wr_stb,
	input  wire logic        rd_stb,
	output pts_flags_t       flags,
	output logic [31:0]      rd_data
);
	localparam logic [18:0] MAX_TK = 19'(`PTS_MAX_TICKS);

	function automatic logic signed [31:0] sat32(input logic signed [63:0] v);
		if (v > 64'sh0000_0000_7fff_ffff)
			return 32'sh7fff_ffff;
		else if (v < -64'sh0000_0000_8000_0000)
			return 32'sh8000_0000;
		else
			return v[31:0];
	endfunction

	logic [31:0]        ctrl_q;
	logic [18:0]        op_dly_q;
	logic [18:0]        rel_dly_q;
	logic [18:0]        op_cnt_q;
	logic [18:0]        rel_cnt_q;
	logic [19:0]        tick_cnt_q;
	logic               tick;
	pts_state_t         state_q;
	pts_state_t         state_d;
	pts_flags_t         flags_q;
	logic [31:0]        expect_q;
	logic [31:0]        remain_q;
	logic [31:0]        rd_q;
	logic [31:0]        rd_mux;
	logic [2:0]         cond_w;
	logic               pick;
	logic               pick_eff;
	logic [31:0]        scaled_w [3];
	logic [31:0]        ratio_w [3];

	// Program tick: delays and the change window run in 5 ms steps
	always_ff @(posedge clk) begin
		if (rst || tick_cnt_q == 20'(TICK_CYC - 1))
			tick_cnt_q <= '0;
		else
			tick_cnt_q <= tick_cnt_q + 20'h0_0001;
	end
	assign tick = (tick_cnt_q == 20'(TICK_CYC - 1));

	// Shared control: channel count, modes, directions, delays
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_q    <= {30'h0000_0000, `PTS_CNT_RST};
			op_dly_q  <= 19'(`PTS_OP_DEF_TK);
			rel_dly_q <= 19'(`PTS_REL_DEF_TK);
		end else if (wr_stb) begin
			if (addr == `PTS_A_CTRL)
				ctrl_q <= wr_data & 32'h0007_7773;
			// Delays clamp at the longest setting
			if (addr == `PTS_A_OPDLY)
				op_dly_q <= (wr_data > 32'(MAX_TK)) ? MAX_TK : wr_data[18:0];
			if (addr == `PTS_A_RELDLY)
				rel_dly_q <= (wr_data > 32'(MAX_TK)) ? MAX_TK : wr_data[18:0];
		end
	end

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : ch
			localparam logic [7:0] CB =
				8'(`PTS_CH_BASE + g * `PTS_CH_STRIDE);
			pts_chan_cfg_t      cfg_q;
			logic signed [31:0] scaled_q;
			logic signed [31:0] ratio_q;
			logic signed [31:0] hist_q [`PTS_WIN_TICKS];
			logic               cond_q;
			logic               en;
			logic               set_c;
			logic               hold_c;
			pts_mode_t          mode;

			assign mode = pts_mode_t'(ctrl_q[`PTS_F_MODE + g*`PTS_F_MSTRIDE +: 3]);
			// Channel count 0 acts as one
			assign en = (g == 0) || (ctrl_q[1:0] > 2'(g));

			always_ff @(posedge clk) begin
				if (rst) begin
					cfg_q.level <= `PTS_LEVEL_RST;
					cfg_q.hyst  <= `PTS_HYST_RST;
					cfg_q.mult  <= `PTS_MULT_RST;
					cfg_q.blk   <= '0;
				end else if (wr_stb && addr[7:4] == CB[7:4]) begin
					unique case (addr[3:0])
						`PTS_O_LEVEL: cfg_q.level <= wr_data;
						`PTS_O_HYST:  cfg_q.hyst  <= (wr_data > `PTS_HYST_MAX) ?
							`PTS_HYST_MAX : wr_data;
						`PTS_O_MULT:  cfg_q.mult  <= wr_data;
						`PTS_O_BLK:   cfg_q.blk   <= wr_data;
						default: ;
					endcase
				end
			end

			// Q16.16 multiplier; 1.0 passes the value through
			always_ff @(posedge clk) begin
				if (rst)
					scaled_q <= '0;
				else
					scaled_q <= sat32((64'($signed(meas[g]))
						* 64'(cfg_q.mult)) >>> `PTS_QBITS);
			end

			// Ratio in Q16.16; a zero level reads as zero
			always_ff @(posedge clk) begin
				if (rst || cfg_q.level == '0)
					ratio_q <= '0;
				else
					ratio_q <= sat32((64'(scaled_q) <<< `PTS_QBITS)
						/ 64'(cfg_q.level));
			end

			// Samples one tick apart; the oldest is 20 ms back
			always_ff @(posedge clk) begin
				if (rst) begin
					for (int i = 0; i < `PTS_WIN_TICKS; i++)
						hist_q[i] <= '0;
				end else if (tick) begin
					hist_q[0] <= scaled_q;
					for (int i = 1; i < `PTS_WIN_TICKS; i++)
						hist_q[i] <= hist_q[i-1];
				end
			end

			always_comb begin
				logic signed [32:0] x;
				logic signed [32:0] ax;
				logic signed [32:0] lv;
				logic signed [32:0] hamt;
				logic signed [32:0] dl;
				logic signed [32:0] sd;
				logic signed [32:0] adl;
				logic signed [32:0] aold;
				logic signed [32:0] alv;
				logic signed [63:0] dprod;
				logic [63:0]        hprod;
				x     = 33'(scaled_q);
				ax    = (x < 0) ? -x : x;
				lv    = 33'(cfg_q.level);
				alv   = (lv < 0) ? -lv : lv;
				hprod = 64'(alv) * 64'(cfg_q.hyst);
				hamt  = 33'(hprod / `PTS_PPM);
				dl    = x - 33'(hist_q[`PTS_WIN_TICKS-1]);
				adl   = (dl < 0) ? -dl : dl;
				// Direction bit set selects a falling change
				sd    = ctrl_q[`PTS_F_DIR + g] ? -dl : dl;
				aold  = 33'(hist_q[`PTS_WIN_TICKS-1]);
				aold  = (aold < 0) ? -aold : aold;
				dprod = 64'(adl) * $signed(`PTS_PPM);
				set_c  = 1'b0;
				hold_c = 1'b0;
				unique case (mode)
					PTS_M_OVER: begin
						set_c  = x > lv;
						hold_c = x > lv - hamt;
					end
					PTS_M_OVER_ABS: begin
						set_c  = ax > lv;
						hold_c = ax > lv - hamt;
					end
					PTS_M_UNDER: begin
						set_c  = x < lv && x >= 33'(cfg_q.blk);
						hold_c = x < lv + hamt && x >= 33'(cfg_q.blk);
					end
					PTS_M_UNDER_ABS: begin
						set_c  = ax < lv && ax >= 33'(cfg_q.blk);
						hold_c = ax < lv + hamt && ax >= 33'(cfg_q.blk);
					end
					PTS_M_REL_DIR: begin
						set_c  = sd > 0 && dprod > 64'(aold) * 64'(alv);
						hold_c = sd > 0 && dprod > 64'(aold) * 64'(alv - hamt);
					end
					PTS_M_REL_ABS: begin
						set_c  = dprod > 64'(aold) * 64'(alv);
						hold_c = dprod > 64'(aold) * 64'(alv - hamt);
					end
					PTS_M_DELTA_DIR: begin
						set_c  = sd > lv;
						hold_c = sd > lv - hamt;
					end
					PTS_M_DELTA_ABS: begin
						set_c  = adl > alv;
						hold_c = adl > alv - hamt;
					end
				endcase
			end

			// Once picked up, the wider hysteresis threshold keeps it
			always_ff @(posedge clk) begin
				if (rst)
					cond_q <= 1'b0;
				else
					cond_q <= en && (cond_q ? hold_c : set_c);
			end

			assign cond_w[g]   = cond_q;
			assign scaled_w[g] = scaled_q;
			assign ratio_w[g]  = ratio_q;
		end
	endgenerate

	assign pick     = |cond_w;
	assign pick_eff = pick && !block_in;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			PTS_ST_NORMAL:
				if (pick)
					state_d = block_in ? PTS_ST_BLOCKED : PTS_ST_START;
			PTS_ST_START:
				if (pick_eff && op_cnt_q >= op_dly_q)
					state_d = PTS_ST_TRIP;
				else if (!pick_eff && rel_cnt_q >= rel_dly_q)
					state_d = PTS_ST_NORMAL;
			PTS_ST_TRIP:
				if (!pick_eff && rel_cnt_q >= rel_dly_q)
					state_d = PTS_ST_NORMAL;
			PTS_ST_BLOCKED:
				if (!pick)
					state_d = PTS_ST_NORMAL;
				else if (!block_in)
					state_d = PTS_ST_START;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst)
			state_q <= PTS_ST_NORMAL;
		else
			state_q <= state_d;
	end

	// Blocking mid-start releases like a dropped pick-up
	always_ff @(posedge clk) begin
		if (rst || state_q == PTS_ST_NORMAL || state_q == PTS_ST_BLOCKED) begin
			op_cnt_q  <= '0;
			rel_cnt_q <= '0;
		end else begin
			if (pick_eff) begin
				rel_cnt_q <= '0;
				if (tick && op_cnt_q < op_dly_q)
					op_cnt_q <= op_cnt_q + 19'h0_0001;
			end else if (tick && rel_cnt_q < rel_dly_q) begin
				rel_cnt_q <= rel_cnt_q + 19'h0_0001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			flags_q  <= '0;
			expect_q <= '0;
			remain_q <= '0;
		end else begin
			flags_q.start   <= state_d == PTS_ST_START ||
				state_d == PTS_ST_TRIP;
			flags_q.trip    <= state_d == PTS_ST_TRIP;
			flags_q.blocked <= state_d == PTS_ST_BLOCKED;
			expect_q <= (state_q == PTS_ST_START || state_q == PTS_ST_TRIP) ?
				32'(op_dly_q) : '0;
			remain_q <= (state_q == PTS_ST_START) ?
				32'(op_dly_q - op_cnt_q) : '0;
		end
	end
	assign flags = flags_q;

	always_comb begin
		rd_mux = '0;
		unique case (addr)
			`PTS_A_CTRL:   rd_mux = ctrl_q;
			`PTS_A_OPDLY:  rd_mux = 32'(op_dly_q);
			`PTS_A_RELDLY: rd_mux = 32'(rel_dly_q);
			`PTS_A_STATUS: rd_mux = {25'h000_0000, cond_w, 1'b0,
				flags_q.blocked, flags_q.trip, flags_q.start};
			`PTS_A_EXPECT: rd_mux = expect_q;
			`PTS_A_REMAIN: rd_mux = remain_q;
			`PTS_A_SCALED: rd_mux = scaled_w[0];
			8'h54:         rd_mux = scaled_w[1];
			8'h58:         rd_mux = scaled_w[2];
			`PTS_A_RATIO:  rd_mux = ratio_w[0];
			8'h64:         rd_mux = ratio_w[1];
			8'h68:         rd_mux = ratio_w[2];
			8'h10:         rd_mux = ch[0].cfg_q.level;
			8'h14:         rd_mux = ch[0].cfg_q.hyst;
			8'h18:         rd_mux = ch[0].cfg_q.mult;
			8'h1c:         rd_mux = ch[0].cfg_q.blk;
			8'h20:         rd_mux = ch[1].cfg_q.level;
			8'h24:         rd_mux = ch[1].cfg_q.hyst;
			8'h28:         rd_mux = ch[1].cfg_q.mult;
			8'h2c:         rd_mux = ch[1].cfg_q.blk;
			8'h30:         rd_mux = ch[2].cfg_q.level;
			8'h34:         rd_mux = ch[2].cfg_q.hyst;
			8'h38:         rd_mux = ch[2].cfg_q.mult;
			8'h3c:         rd_mux = ch[2].cfg_q.blk;
			default:       rd_mux = '0;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (rst || !rd_stb)
			rd_q <= '0;
		else
			rd_q <= rd_mux;
	end
	assign rd_data = rd_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence seq_clean_pickup;
		state_q == PTS_ST_NORMAL && pick && !block_in;
	endsequence

	sequence seq_release_done;
		state_q == PTS_ST_TRIP && !pick_eff && rel_cnt_q >= rel_dly_q;
	endsequence

	a_start_on_pickup: assert property (seq_clean_pickup |=>
		flags.start && !flags.trip && !flags.blocked)
		else $error("start missing after clean pick-up");
	a_block_on_pickup: assert property (
		state_q == PTS_ST_NORMAL && pick && block_in |=>
		flags.blocked && !flags.start ##1 op_cnt_q == '0)
		else $error("blocked pick-up not reported");
	a_trip_after_delay: assert property (
		state_q == PTS_ST_START && pick_eff && op_cnt_q >= op_dly_q |=>
		flags.trip && state_q == PTS_ST_TRIP)
		else $error("trip missing after operating delay");
	a_no_early_trip: assert property (
		state_q == PTS_ST_START && op_cnt_q < op_dly_q |=> !flags.trip)
		else $error("trip before operating delay");
	a_release_hold: assert property (
		state_q == PTS_ST_START && !pick_eff && rel_cnt_q < rel_dly_q |=>
		flags.start)
		else $error("start dropped before release delay");
	a_trip_clears: assert property (seq_release_done |=>
		!flags.trip && !flags.start)
		else $error("trip held after release");
	a_unity_scale: assert property (
		ch[0].cfg_q.mult == `PTS_MULT_RST |=>
		scaled_w[0] == $past(meas[0]))
		else $error("unity multiplier changed value");
	a_over_pickup: assert property (
		ctrl_q[6:4] == 3'h0 && !cond_w[0] &&
		$signed(scaled_w[0]) > ch[0].cfg_q.level |=> cond_w[0])
		else $error("over comparison missed");
	a_under_inhibit: assert property (
		ctrl_q[6:4] == 3'h2 &&
		$signed(scaled_w[0]) < ch[0].cfg_q.blk |=> !cond_w[0])
		else $error("under comparison not inhibited");
	a_remain_count: assert property (
		state_q == PTS_ST_START |=> remain_q == 32'($past(op_dly_q) -
		$past(op_cnt_q)))
		else $error("remaining time wrong");
	a_read_once: assert property (
		rd_stb && addr == `PTS_A_STATUS |=> rd_data[2:0] ==
		{$past(flags_q.blocked), $past(flags_q.trip), $past(flags_q.start)}
		##1 ($past(rd_stb) || rd_data == '0))
		else $error("status read data wrong");
endmodule

// File: hdl/pts_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef PTS_MAP_SVH
`define PTS_MAP_SVH
`define PTS_A_CTRL      8'h00
`define PTS_A_OPDLY     8'h04
`define PTS_A_RELDLY    8'h08
`define PTS_A_STATUS    8'h40
`define PTS_A_EXPECT    8'h44
`define PTS_A_REMAIN    8'h48
`define PTS_A_SCALED    8'h50
`define PTS_A_RATIO     8'h60
`define PTS_CH_BASE     8'h10
`define PTS_CH_STRIDE   8'h10
`define PTS_O_LEVEL     4'h0
`define PTS_O_HYST      4'h4
`define PTS_O_MULT      4'h8
`define PTS_O_BLK       4'hc
`define PTS_F_CNT       0
`define PTS_F_MODE      4
`define PTS_F_MSTRIDE   4
`define PTS_F_DIR       16
`define PTS_CNT_RST     2'h1
`define PTS_LEVEL_RST   32'h0000_0064
`define PTS_HYST_RST    32'h0000_7530
`define PTS_HYST_MAX    32'h0007_a120
`define PTS_PPM         64'h0000_0000_000f_4240
`define PTS_MULT_RST    32'h0001_0000
`define PTS_QBITS       16
`define PTS_CLK_NS      8
`define PTS_TICK_MS     5
`define PTS_TICK_CYC    ((`PTS_TICK_MS * 1000000) / `PTS_CLK_NS)
`define PTS_WIN_MS      20
`define PTS_WIN_TICKS   (`PTS_WIN_MS / `PTS_TICK_MS)
`define PTS_MAX_S       1800
`define PTS_MAX_TICKS   ((`PTS_MAX_S * 1000) / `PTS_TICK_MS)
`define PTS_OP_DEF_MS   40
`define PTS_REL_DEF_MS  60
`define PTS_OP_DEF_TK   (`PTS_OP_DEF_MS / `PTS_TICK_MS)
`define PTS_REL_DEF_TK  (`PTS_REL_DEF_MS / `PTS_TICK_MS)
`endif

// File: hdl/pts_pkg.sv
// Types shared by the programmable threshold stage
package pts_pkg;
	typedef enum logic [2:0] {
		PTS_M_OVER,
		PTS_M_OVER_ABS,
		PTS_M_UNDER,
		PTS_M_UNDER_ABS,
		PTS_M_REL_DIR,
		PTS_M_REL_ABS,
		PTS_M_DELTA_DIR,
		PTS_M_DELTA_ABS
	} pts_mode_t;

	typedef enum {
		PTS_ST_NORMAL,
		PTS_ST_START,
		PTS_ST_TRIP,
		PTS_ST_BLOCKED
	} pts_state_t;

	typedef struct packed {
		logic start;
		logic trip;
		logic blocked;
	} pts_flags_t;

	typedef struct packed {
		logic signed [31:0] level;
		logic [31:0]        hyst;
		logic signed [31:0] mult;
		logic signed [31:0] blk;
	} pts_chan_cfg_t;
endpackage

// File: verification/pts_meas_src.sv
// Measurement producer and blocking source facing the stage inputs
`timescale 1ns/10ps

module pts_meas_src (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [2:0][31:0] tgt,
	input  wire logic             blk_req,
	output logic      [2:0][31:0] meas,
	output logic                  block_in
);
	// Values step at once: a producer has no slew limit to hide behind
	always_ff @(posedge clk) begin
		if (rst) begin
			meas <= '0;
		end else begin
			meas <= tgt;
		end
	end

	// One cycle of latency, far inside the 40 ms default operating delay before trip
	always_ff @(posedge clk) begin
		if (rst) begin
			block_in <= 1'b0;
		end else begin
			block_in <= blk_req;
		end
	end
endmodule

// File: verification/testbench.sv
// Self-checking bench for the programmable threshold stage
`timescale 1ns/10ps
`include "pts_map.svh"

`define CHK(a, e) begin compares++; if ((a) !== (e)) begin \
	miscompares++; $display("[ERR] %0t got %h exp %h", $time, a, e); \
	end end

module testbench;
	import pts_pkg::*;
	logic             clk;
	logic             rst;
	logic [2:0][31:0] tgt;
	logic             blk_req;
	logic [2:0][31:0] meas;
	logic             block_in;
	logic [7:0]       addr;
	logic [31:0]      wr_data;
	logic             wr_stb;
	logic             rd_stb;
	pts_flags_t       flags;
	logic [31:0]      rd_data;
	logic [31:0]      expq[$];
	logic [31:0]      ex;
	logic             rd_was;
	logic             rd_st;
	logic [2:0]       fq[$];
	logic [2:0]       fx;
	int               miscompares;
	int               compares;
	int               cycles;
	int               seed;
	int               k;
	logic [31:0]      tm [12];
	logic [31:0]      tp [12];
	logic [31:0]      tq [12];
	logic [31:0]      te [12];

	pts_stage #(.TICK_CYC(10)) pts_stage_i (
		.clk     (clk),
		.rst     (rst),
		.meas    (meas),
		.block_in(block_in),
		.addr    (addr),
		.wr_data (wr_data),
		.wr_stb  (wr_stb),
		.rd_stb  (rd_stb),
		.flags   (flags),
		.rd_data (rd_data)
	);

	pts_meas_src pts_meas_src_i (
		.clk     (clk),
		.rst     (rst),
		.tgt     (tgt),
		.blk_req (blk_req),
		.meas    (meas),
		.block_in(block_in)
	);

	always #4 clk = ~clk;

	task automatic stop_test();
		if (miscompares == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr    <= a;
		wr_data <= d;
		wr_stb  <= 1'b1;
		@(posedge clk);
		wr_stb  <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		expq.push_back(e);
		if (a == 8'h40)
			fq.push_back({e[0], e[1], e[2]});
		addr   <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	always @(posedge clk) begin
		rd_was <= rd_stb;
		rd_st  <= rd_stb && addr == 8'h40;
	end

	// Status reads fall in steady states, so the flag pins must agree
	always @(negedge clk) begin
		if (rd_was === 1'b1) begin
			ex = expq.pop_front();
			`CHK(rd_data, ex)
		end
		if (rd_st === 1'b1) begin
			fx = fq.pop_front();
			`CHK(flags, fx)
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles > 20000) begin
			miscompares++;
			stop_test();
		end
	end

	initial begin
		clk = 0; rst = 1; tgt = '0; blk_req = 0; addr = '0;
		wr_data = '0; wr_stb = 0; rd_stb = 0; rd_was = 0; rd_st = 0;
		miscompares = 0; compares = 0; cycles = 0; seed = 32'h8cec;
		// Mode (bit 12 picks falling), value before, value after, status
		tm = '{0, 0, 1, 2, 2, 3, 3, 4, 5, 6, 7, 32'h1006};
		tp = '{0, 0, 0, 200, 200, 200, 0, 1000, 2000, 500, 500, 500};
		tq = '{200, -200, -200, 50, -50, -50, -150, 2000, 1000, 0, 0, 0};
		te = '{32'h11, 0, 32'h11, 32'h11, 0, 32'h11, 0, 32'h11,
			32'h11, 0, 32'h11, 32'h11};
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rd(8'h00, 32'h0000_0001);
		rd(8'h04, 32'h0000_0008);
		rd(8'h08, 32'h0000_000c);
		rd(8'h10, 32'h0000_0064);
		rd(8'h14, 32'h0000_7530);
		rd(8'h18, 32'h0001_0000);
		rd(8'h1c, 32'h0000_0000);
		rd(8'hfc, 32'h0000_0000);
		rd(8'h40, 32'h0000_0000);
		// Scaling by 2.0 and ratio against the reset level of 100
		k = 1 + ({$random(seed)} % 15);
		wr(8'h18, 32'h0002_0000);
		wr(8'h04, 32'h0000_03e8);
		tgt[0] <= 50 * k;
		cyc(6);
		rd(8'h50, 100 * k);
		rd(8'h60, k << 16);
		wr(8'h18, 32'h0001_0000);
		tgt[0] <= 0;
		// Every comparator mode, release delay zero
		wr(8'h08, 32'h0000_0000);
		for (int i = 0; i < 12; i++) begin
			wr(8'h00, 32'h0000_0001 | (tm[i] << 4));
			tgt[0] <= tp[i];
			cyc(60);
			tgt[0] <= tq[i];
			cyc(20);
			rd(8'h40, te[i]);
		end
		// Disabled channel gives nothing until the count covers it
		wr(8'h00, 32'h0000_0001);
		tgt[0] <= 0;
		tgt[1] <= 200;
		cyc(20);
		rd(8'h40, 32'h0000_0000);
		wr(8'h00, 32'h0000_0002);
		cyc(20);
		rd(8'h40, 32'h0000_0021);
		tgt[1] <= 0;
		wr(8'h00, 32'h0000_0003);
		cyc(20);
		// Blocking present at pick-up
		blk_req <= 1'b1;
		cyc(3);
		tgt[2] <= 200;
		cyc(20);
		rd(8'h40, 32'h0000_0044);
		rd(8'h48, 32'h0000_0000);
		blk_req <= 1'b0;
		cyc(10);
		rd(8'h40, 32'h0000_0041);
		tgt[2] <= 0;
		cyc(20);
		rd(8'h40, 32'h0000_0000);
		// Definite delay, hysteresis hold, then release
		wr(8'h04, 32'h0000_0002);
		wr(8'h08, 32'h0000_0003);
		tgt[0] <= 200;
		cyc(5);
		rd(8'h40, 32'h0000_0011);
		rd(8'h44, 32'h0000_0002);
		cyc(40);
		rd(8'h40, 32'h0000_0013);
		rd(8'h48, 32'h0000_0000);
		tgt[0] <= 98;
		cyc(8);
		rd(8'h40, 32'h0000_0013);
		tgt[0] <= 0;
		cyc(8);
		rd(8'h40, 32'h0000_0003);
		cyc(60);
		rd(8'h40, 32'h0000_0000);
		rd(8'h44, 32'h0000_0000);
		cyc(4);
		stop_test();
	end
endmodule
